// ===== radio_irq_pkg.sv
// constants and carrier types for the radio core interrupt aggregator
// assumes an 8-bit special-function register port on the system clock
package radio_irq_pkg;

  // cpu interrupt vector numbers of the two requests
  localparam int VEC_ERROR = 0;
  localparam int VEC_EVENT = 12;

  // register offsets on the special-function register port
  localparam logic [7:0] ADDR_FLAGS_LOW = 8'hE9;
  localparam logic [7:0] ADDR_FLAGS_HIGH = 8'h91;
  localparam logic [7:0] ADDR_ERR_FLAGS = 8'hBF;
  localparam logic [7:0] ADDR_MASK_LOW = 8'hA3;
  localparam logic [7:0] ADDR_MASK_HIGH = 8'hA4;
  localparam logic [7:0] ADDR_ERR_MASK = 8'hA5;

  // reset value and all-ones byte
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;

  // implemented bits of each flag register, the rest read as zero
  localparam logic [7:0] IMPL_LOW = 8'hFE;
  localparam logic [7:0] IMPL_HIGH = 8'h3F;
  localparam logic [7:0] IMPL_ERR = 8'h7F;

  // bit positions of the low event flag register
  localparam int BIT_RXEN_CLEARED = 7;
  localparam int BIT_FRAME_RX = 6;
  localparam int BIT_FILTER_PASS = 5;
  localparam int BIT_SRC_HIT = 4;
  localparam int BIT_SRC_DONE = 3;
  localparam int BIT_RX_THRESHOLD = 2;
  localparam int BIT_SFD = 1;
  localparam int BIT_RESERVED = 0;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // event sources of the radio core, levels on the system clock
  typedef struct packed {
    logic [7:0] rxen_value;      // receiver_request_reg contents
    logic frame_rx_done;
    logic filter_pass;
    logic src_hit;
    logic src_search_done;
    logic rx_over_threshold;     // receive_queue count above threshold
    logic packet_read_more;      // packet read out, more complete ones stored
    logic sfd_rx;
    logic sfd_tx;
    logic [5:0] high_events;     // wait resumed, stopped, manual, idle, tx done, ack done
    logic [6:0] error_events;    // strobe, tx under, tx over, rx under, rx over, abort, lock
  } radio_src_s;

endpackage

// ===== radio_flag_bank.sv
// one 8-bit source flag register: rising-edge set, write-zero clear
// assumes sources are levels on the same clock as the register
`timescale 1ns/1ps
module radio_flag_bank #(
  parameter logic [7:0] IMPL = 8'hFF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] src_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] flags_o,
  output logic clr_o
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] src_d_r;
  logic [7:0] rise;
  logic [7:0] keep;

  assign keep = wr_i ? wdata_i : radio_irq_pkg::ALL_ONES;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign rise[gi] = src_i[gi] & ~src_d_r[gi];
      // set wins over a clear in the same cycle
      assign flags_nxt[gi] = ((flags_r[gi] & keep[gi]) | rise[gi]) & IMPL[gi];
    end
  endgenerate

  assign clr_o = wr_i & (|(flags_r & ~wdata_i));
  assign flags_o = flags_r;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flags_r <= radio_irq_pkg::RESET_BYTE;
      src_d_r <= radio_irq_pkg::RESET_BYTE;
    end else begin
      flags_r <= flags_nxt;
      src_d_r <= src_i;
    end
  end

endmodule // radio_flag_bank

// ===== radio_core_interrupt_aggregator.sv
// radio core interrupt aggregator: source flags, masks, top flags, requests
// assumes a cpu register port and enable bits held by the cpu interrupt unit
// Function
// - two requests: error on vector 0, normal events on vector 12
// - every radio error reaches only the error request
// - all normal event flags combine into one request
// - requests fire on a 0 to 1 change only, not on a level
// - each flag bit has its own mask bit; bits 2 and 1 are shared by several sources
// - a source counts toward its request only while its mask bit is set
// - a cleared mask bit never stops its flag from being set
// - each request is gated by its own cpu enable bit
// - each request sets its own top flag, error and event apart
// - clearing one flag while others stay pending raises a new request
// - bit 7 sets when the receiver enable value falls to zero
// - bit 6 sets when a complete frame has been received
// - bit 5 sets when a frame passes filtering
// - bit 2 sets on threshold, frame received, or readout with more
// - bit 1 sets on a start-of-frame delimiter received or sent
// - high flag register bits 5..0 hold the six processor and tx events
// - error flag register bits 6..0 hold the seven error events
`timescale 1ns/1ps
module radio_core_interrupt_aggregator (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire radio_irq_pkg::sfr_req_s sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire radio_irq_pkg::radio_src_s src_i,
  input wire logic radio_error_top_enable_i,
  input wire logic radio_event_top_enable_i,
  input wire logic radio_error_top_clear_i,
  input wire logic radio_event_top_clear_i,
  output logic radio_error_top_flag_o,
  output logic radio_event_top_flag_o,
  output logic radio_error_irq_o,
  output logic radio_event_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_low;
  logic wr_high;
  logic wr_err;
  logic wr_mlow;
  logic wr_mhigh;
  logic wr_merr;
  assign wr_low = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_FLAGS_LOW);
  assign wr_high = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_FLAGS_HIGH);
  assign wr_err = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_ERR_FLAGS);
  assign wr_mlow = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_MASK_LOW);
  assign wr_mhigh = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_MASK_HIGH);
  assign wr_merr = sfr_req_i.wr && (sfr_req_i.addr == radio_irq_pkg::ADDR_ERR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // source flag registers

  logic rxen_nonzero_r;
  logic rxen_cleared;
  logic [7:0] low_src;
  logic [7:0] flags_low;
  logic [7:0] flags_high;
  logic [7:0] flags_err;
  logic clr_low;
  logic clr_high;
  logic clr_err;

  assign rxen_cleared = rxen_nonzero_r && (src_i.rxen_value == radio_irq_pkg::RESET_BYTE);

  assign low_src[radio_irq_pkg::BIT_RXEN_CLEARED] = rxen_cleared;
  assign low_src[radio_irq_pkg::BIT_FRAME_RX] = src_i.frame_rx_done;
  assign low_src[radio_irq_pkg::BIT_FILTER_PASS] = src_i.filter_pass;
  assign low_src[radio_irq_pkg::BIT_SRC_HIT] = src_i.src_hit;
  assign low_src[radio_irq_pkg::BIT_SRC_DONE] = src_i.src_search_done;
  assign low_src[radio_irq_pkg::BIT_RX_THRESHOLD] = src_i.rx_over_threshold
      | src_i.frame_rx_done | src_i.packet_read_more;
  assign low_src[radio_irq_pkg::BIT_SFD] = src_i.sfd_rx | src_i.sfd_tx;
  assign low_src[radio_irq_pkg::BIT_RESERVED] = 1'b0;

  radio_flag_bank #(.IMPL(radio_irq_pkg::IMPL_LOW)) u_low (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .src_i(low_src),
    .wr_i(wr_low),
    .wdata_i(sfr_req_i.wdata),
    .flags_o(flags_low),
    .clr_o(clr_low)
  );

  radio_flag_bank #(.IMPL(radio_irq_pkg::IMPL_HIGH)) u_high (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .src_i({2'b00, src_i.high_events}),
    .wr_i(wr_high),
    .wdata_i(sfr_req_i.wdata),
    .flags_o(flags_high),
    .clr_o(clr_high)
  );

  radio_flag_bank #(.IMPL(radio_irq_pkg::IMPL_ERR)) u_err (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .src_i({1'b0, src_i.error_events}),
    .wr_i(wr_err),
    .wdata_i(sfr_req_i.wdata),
    .flags_o(flags_err),
    .clr_o(clr_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // masks, combining and edge detection

  logic [7:0] mask_low_r;
  logic [7:0] mask_high_r;
  logic [7:0] mask_err_r;
  logic event_comb;
  logic error_comb;
  logic event_prev_r;
  logic error_prev_r;
  logic event_edge;
  logic error_edge;

  assign event_comb = (|(flags_low & mask_low_r)) | (|(flags_high & mask_high_r));
  assign error_comb = |(flags_err & mask_err_r);
  assign event_edge = event_comb & ~event_prev_r;
  assign error_edge = error_comb & ~error_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // top flags and requests

  logic event_top_r;
  logic error_top_r;
  logic [7:0] rdata_r;
  logic [7:0] rd_sel;

  assign rd_sel =
      (sfr_req_i.addr == radio_irq_pkg::ADDR_FLAGS_LOW) ? flags_low :
      (sfr_req_i.addr == radio_irq_pkg::ADDR_FLAGS_HIGH) ? flags_high :
      (sfr_req_i.addr == radio_irq_pkg::ADDR_ERR_FLAGS) ? flags_err :
      (sfr_req_i.addr == radio_irq_pkg::ADDR_MASK_LOW) ? mask_low_r :
      (sfr_req_i.addr == radio_irq_pkg::ADDR_MASK_HIGH) ? mask_high_r :
      (sfr_req_i.addr == radio_irq_pkg::ADDR_ERR_MASK) ? mask_err_r :
      radio_irq_pkg::RESET_BYTE;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mask_low_r <= radio_irq_pkg::RESET_BYTE;
      mask_high_r <= radio_irq_pkg::RESET_BYTE;
      mask_err_r <= radio_irq_pkg::RESET_BYTE;
      rxen_nonzero_r <= 1'b0;
      event_prev_r <= 1'b0;
      error_prev_r <= 1'b0;
      event_top_r <= 1'b0;
      error_top_r <= 1'b0;
      rdata_r <= radio_irq_pkg::RESET_BYTE;
    end else begin
      if (wr_mlow) mask_low_r <= sfr_req_i.wdata & radio_irq_pkg::IMPL_LOW;
      if (wr_mhigh) mask_high_r <= sfr_req_i.wdata & radio_irq_pkg::IMPL_HIGH;
      if (wr_merr) mask_err_r <= sfr_req_i.wdata & radio_irq_pkg::IMPL_ERR;
      rxen_nonzero_r <= (src_i.rxen_value != radio_irq_pkg::RESET_BYTE);
      // a clear write rearms the edge detector
      event_prev_r <= (clr_low | clr_high) ? 1'b0 : event_comb;
      error_prev_r <= clr_err ? 1'b0 : error_comb;
      // set wins over the software clear
      event_top_r <= (event_top_r & ~radio_event_top_clear_i) | event_edge;
      error_top_r <= (error_top_r & ~radio_error_top_clear_i) | error_edge;
      if (sfr_req_i.rd) rdata_r <= rd_sel;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign radio_event_top_flag_o = event_top_r;
  assign radio_error_top_flag_o = error_top_r;
  assign radio_error_irq_o = error_top_r & radio_error_top_enable_i;
  assign radio_event_irq_o = event_top_r & radio_event_top_enable_i;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_event_clear;
    (clr_low || clr_high);
  endsequence

  sequence s_still_pending;
    ##1 event_comb;
  endsequence

  AST_IRQ_GATED: assert property (
    !radio_event_top_enable_i |-> !radio_event_irq_o)
    else $error("event request passed without its enable");

  AST_ERR_EDGE_SETS: assert property (
    $rose(error_comb) && !error_prev_r |=> radio_error_top_flag_o)
    else $error("error top flag not set on masked error edge");

  AST_EVT_EDGE_SETS: assert property (
    event_edge |=> radio_event_top_flag_o)
    else $error("event top flag not set on combined edge");

  AST_ERR_ONLY_FROM_ERR: assert property (
    $rose(radio_error_top_flag_o) |-> $past(error_comb))
    else $error("error top flag set without an error source");

  AST_LEVEL_NO_RETRIGGER: assert property (
    radio_event_top_clear_i && event_prev_r && event_comb |=> !radio_event_top_flag_o)
    else $error("steady level retriggered the event request");

  AST_MASK_NO_BLOCK: assert property (
    $rose(src_i.sfd_rx || src_i.sfd_tx) && !wr_low |=> flags_low[radio_irq_pkg::BIT_SFD])
    else $error("sfd flag not set while masked");

  AST_REARM: assert property (
    s_event_clear ##0 s_still_pending |=> radio_event_top_flag_o)
    else $error("no new request after clearing with others pending");

  AST_RXEN_ZERO: assert property (
    rxen_nonzero_r && (src_i.rxen_value == radio_irq_pkg::RESET_BYTE) && !wr_low
    |=> flags_low[radio_irq_pkg::BIT_RXEN_CLEARED])
    else $error("receiver enable fall to zero not flagged");

  AST_MASKED_SILENT: assert property (
    (mask_low_r == radio_irq_pkg::RESET_BYTE) && (mask_high_r == radio_irq_pkg::RESET_BYTE)
    |-> !event_comb)
    else $error("masked sources reached the event request");

endmodule // radio_core_interrupt_aggregator

// ===== cpu_irq_model.sv
// cpu interrupt unit model: top enable bits and top flag clear pulses
// assumes the aggregator runs on the same system clock and reset
`timescale 1ns/1ps
module cpu_irq_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] enable_set_i,
  input wire logic [1:0] ack_i,
  output logic radio_error_top_enable_o,
  output logic radio_event_top_enable_o,
  output logic radio_error_top_clear_o,
  output logic radio_event_top_clear_o
);
  ////////////////////////////////////////////////////////////////////////////
  // bit 1 is the error request, bit 0 the event request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      radio_error_top_enable_o <= 1'b0;
      radio_event_top_enable_o <= 1'b0;
      radio_error_top_clear_o <= 1'b0;
      radio_event_top_clear_o <= 1'b0;
    end else begin
      radio_error_top_enable_o <= enable_set_i[1];
      radio_event_top_enable_o <= enable_set_i[0];
      radio_error_top_clear_o <= ack_i[1];
      radio_event_top_clear_o <= ack_i[0];
    end
  end
endmodule // cpu_irq_model

// ===== radio_core_interrupt_aggregator_tb.sv
// testbench for the radio core interrupt aggregator
// assumes a 20 MHz system clock and synchronous active-low reset
`timescale 1ns/1ps
module radio_core_interrupt_aggregator_tb;
  localparam logic [7:0] FL = radio_irq_pkg::ADDR_FLAGS_LOW;
  localparam logic [7:0] FH = radio_irq_pkg::ADDR_FLAGS_HIGH;
  localparam logic [7:0] FE = radio_irq_pkg::ADDR_ERR_FLAGS;
  localparam logic [7:0] ML = radio_irq_pkg::ADDR_MASK_LOW;
  localparam logic [7:0] MH = radio_irq_pkg::ADDR_MASK_HIGH;
  localparam logic [7:0] ME = radio_irq_pkg::ADDR_ERR_MASK;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  radio_irq_pkg::sfr_req_s req = '0;
  radio_irq_pkg::radio_src_s src = '0;
  radio_irq_pkg::radio_src_s v;
  logic [7:0] rdata;
  logic [1:0] en_set = 2'b00;
  logic [1:0] ack = 2'b00;
  logic err_en, evt_en, err_clr, evt_clr, err_top, evt_top, err_irq, evt_irq;
  logic [7:0] regs [6] = '{FL, FH, FE, ML, MH, ME};
  int errors = 0;
  int checks = 0;
  always #25 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  radio_core_interrupt_aggregator dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .sfr_req_i(req), .sfr_rdata_o(rdata), .src_i(src),
    .radio_error_top_enable_i(err_en), .radio_event_top_enable_i(evt_en),
    .radio_error_top_clear_i(err_clr), .radio_event_top_clear_i(evt_clr),
    .radio_error_top_flag_o(err_top), .radio_event_top_flag_o(evt_top),
    .radio_error_irq_o(err_irq), .radio_event_irq_o(evt_irq));
  cpu_irq_model cpu (.clk_i(clk_i), .resetn_i(resetn_i), .enable_set_i(en_set),
    .ack_i(ack), .radio_error_top_enable_o(err_en), .radio_event_top_enable_o(evt_en),
    .radio_error_top_clear_o(err_clr), .radio_event_top_clear_o(evt_clr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    check(rdata, exp);
    tick(1);
  endtask
  task automatic pulse(input radio_irq_pkg::radio_src_s s);
    src = s;
    tick(1);
    src = '0;
    tick(1);
  endtask
  task automatic tops(input logic [7:0] exp);
    check({4'h0, err_top, evt_top, err_irq, evt_irq}, exp);
  endtask
  task automatic ack_top(input logic [1:0] which);
    ack = which;
    tick(1);
    ack = 2'b00;
    tick(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'h10, 8'h00);
    tops(8'h00);
  endtask
  task automatic t_low_flags();
    v = '0;
    v.rxen_value = 8'h05;
    pulse(v);
    rd(FL, 8'h80);
    wr(FL, 8'h00);
    v = '0;
    v.rx_over_threshold = 1'b1;
    pulse(v);
    rd(FL, 8'h04);
    wr(FL, 8'h00);
    v = '0;
    v.frame_rx_done = 1'b1;
    pulse(v);
    rd(FL, 8'h44);
    wr(FL, 8'h00);
    v = '0;
    v.packet_read_more = 1'b1;
    pulse(v);
    rd(FL, 8'h04);
    wr(FL, 8'h00);
    v = '0;
    v.filter_pass = 1'b1;
    v.src_hit = 1'b1;
    v.src_search_done = 1'b1;
    v.sfd_rx = 1'b1;
    pulse(v);
    wr(FL, 8'hFF);
    rd(FL, 8'h3A);
    wr(FL, 8'hF7);
    rd(FL, 8'h32);
    wr(FL, 8'h00);
    v = '0;
    v.sfd_tx = 1'b1;
    pulse(v);
    rd(FL, 8'h02);
    wr(FL, 8'h00);
    tops(8'h00);
  endtask
  task automatic t_high_err();
    v = '0;
    v.high_events = 6'h3F;
    v.error_events = 7'h7F;
    pulse(v);
    rd(FH, 8'h3F);
    rd(FE, 8'h7F);
    tops(8'h00);
    wr(FH, 8'h00);
    wr(FE, 8'h00);
    wr(MH, 8'hFF);
    rd(MH, 8'h3F);
    wr(MH, 8'h00);
  endtask
  task automatic t_event();
    wr(ML, 8'h02);
    en_set = 2'b01;
    v = '0;
    v.sfd_rx = 1'b1;
    src = v;
    tick(2);
    tops(8'h05);
    ack_top(2'b01);
    tops(8'h00);
    tick(4);
    tops(8'h00);
    src = '0;
    wr(FL, 8'h00);
  endtask
  task automatic t_error();
    wr(ME, 8'h01);
    en_set = 2'b11;
    v = '0;
    v.error_events = 7'h01;
    pulse(v);
    tops(8'h0A);
    en_set = 2'b01;
    tick(2);
    tops(8'h08);
    wr(FE, 8'h00);
    ack_top(2'b10);
    tops(8'h00);
  endtask
  task automatic t_rearm();
    wr(ML, 8'h06);
    v = '0;
    v.sfd_rx = 1'b1;
    v.rx_over_threshold = 1'b1;
    pulse(v);
    tops(8'h05);
    ack_top(2'b01);
    wr(FL, 8'hFD);
    tick(2);
    tops(8'h05);
    ack_top(2'b01);
    wr(FL, 8'h00);
    tick(3);
    tops(8'h00);
  endtask
  task automatic t_mid_reset();
    wr(ML, 8'h02);
    v = '0;
    v.sfd_rx = 1'b1;
    pulse(v);
    tops(8'h05);
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    tops(8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_low_flags();
    t_high_err();
    t_event();
    t_error();
    t_rearm();
    t_mid_reset();
    end_of_test();
  end
  // tests take some 140 cycles (7 us); allow far more
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
endmodule // radio_core_interrupt_aggregator_tb
